//--- verilog/rxem_pkg.sv
// Constants and types shared by the error monitor and its serial port
// Function
// R1 - Config bit 3 picks which event count reads
// R2 - Clock or lock loss advances recovery event count
// R3 - Config bit 2 clears recovery event count
// R4 - Config bit 1 clears data event count
// R5 - Config bit 0 enables both event counters
// R6 - Monitor bit 4 keeps count across runs
// R7 - Monitor bit 3 ignores code errors, lock too
// R8 - Monitor bit 2 clears run and window counts
// R9 - Monitor bit 1 picks run or window count
// R10 - Monitor bit 0 keeps receiving past threshold
// R11 - Count above threshold halts parallel data output
// R12 - Threshold high byte at 2F, resets zero
// R13 - Rate field bits 6:4, 111 when unlocked
// R14 - Event status reads selected event count
// R15 - Data error count reads at 3E and 3F
// R16 - Status bits: lock 3, signal detect 2,1
package rxem_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_EVT_CFG   = 8'h2b;
    localparam logic [7:0] ADDR_MON_CTL   = 8'h2d;
    localparam logic [7:0] ADDR_THR_LO    = 8'h2e;
    localparam logic [7:0] ADDR_THR_HI    = 8'h2f;
    localparam logic [7:0] ADDR_RATE      = 8'h3b;
    localparam logic [7:0] ADDR_LOCK_STAT = 8'h3c;
    localparam logic [7:0] ADDR_EVT_STAT  = 8'h3d;
    localparam logic [7:0] ADDR_ERR_LO    = 8'h3e;
    localparam logic [7:0] ADDR_ERR_HI    = 8'h3f;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int EVT_SEL_BIT      = 3;
    localparam int EVT_CDR_RST_BIT  = 2;
    localparam int EVT_LINK_RST_BIT = 1;
    localparam int EVT_EN_BIT       = 0;
    localparam int MON_ACCUM_BIT    = 4;
    localparam int MON_CODE_DIS_BIT = 3;
    localparam int MON_CLEAR_BIT    = 2;
    localparam int MON_WIN_SEL_BIT  = 1;
    localparam int MON_NORM_DIS_BIT = 0;
    localparam int STAT_LOCK_BIT    = 3;
    localparam int STAT_SD1_BIT     = 2;
    localparam int STAT_SD0_BIT     = 1;
    localparam int RATE_LSB         = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values, writable masks and rate codes
    localparam logic [7:0] EVT_CFG_RST   = 8'h00;
    localparam logic [7:0] MON_CTL_RST   = 8'h00;
    localparam logic [7:0] THR_LO_RST    = 8'h10;
    localparam logic [7:0] THR_HI_RST    = 8'h00;
    localparam logic [7:0] EVT_CFG_MASK  = 8'h0f;
    localparam logic [7:0] MON_CTL_MASK  = 8'h1f;
    localparam logic [2:0] RATE_270M     = 3'h1;
    localparam logic [2:0] RATE_1G485    = 3'h3;
    localparam logic [2:0] RATE_2G97     = 3'h6;
    localparam logic [2:0] RATE_UNLOCKED = 3'h7;

    // Serial management port device address
    localparam logic [6:0] SMB_DEV_ADDR  = 7'h2c;

    ////////////////////////////////////////////////////////////////////////
    // Timing: recovered clock counts as lost after this long without an edge
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int CLK_LOSS_NS       = 1000;
    localparam logic [7:0] CLK_LOSS_CYC = 8'((CLK_LOSS_NS
        + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////
    // Serial port states
    typedef enum logic [2:0] {
        SMB_IDLE,
        SMB_RX,
        SMB_ACK,
        SMB_TX,
        SMB_TXACK
    } rxem_smb_state_t;

    typedef enum logic [1:0] {
        KIND_ADDR,
        KIND_PTR,
        KIND_DATA
    } rxem_kind_t;

endpackage : rxem_pkg

//--- verilog/rxem_smb_slave.sv
// Management serial port slave: byte pointer, auto-increment, read and write
`timescale 1ns/1ps
module rxem_smb_slave (
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic       smb_scl_in,
    input  wire logic       smb_sda_in,
    output logic            smb_sda_out,
    output logic            smb_sda_oe_out,
    output logic            wr_stb_out,
    output logic [7:0]      wr_addr_out,
    output logic [7:0]      wr_data_out,
    output logic [7:0]      rd_addr_out,
    input  wire logic [7:0] rd_data_in
);

    typedef struct packed {
        logic                     scl_s1;
        logic                     scl_s2;
        logic                     scl_s3;
        logic                     sda_s1;
        logic                     sda_s2;
        logic                     sda_s3;
        rxem_pkg::rxem_smb_state_t state;
        rxem_pkg::rxem_kind_t     kind;
        logic [2:0]               cnt;
        logic                     done;
        logic                     rw;
        logic                     acked;
        logic [7:0]               sh;
        logic [7:0]               ptr;
        logic                     oe;
        logic                     wr_stb;
        logic [7:0]               wr_addr;
        logic [7:0]               wr_data;
    } rxem_smb_t;

    rxem_smb_t q;
    rxem_smb_t d;
    logic      rise;
    logic      fall;
    logic      start;
    logic      stop;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d        = q;
        d.scl_s1 = smb_scl_in;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = smb_sda_in;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        d.wr_stb = 1'b0;
        rise     = q.scl_s2 & ~q.scl_s3;
        fall     = ~q.scl_s2 & q.scl_s3;
        start    = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
        stop     = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
        unique case (q.state)
            rxem_pkg::SMB_IDLE: ;
            rxem_pkg::SMB_RX: begin
                if (rise) begin
                    d.sh  = {q.sh[6:0], q.sda_s2};
                    d.cnt = q.cnt + 3'h1;
                    d.done = (q.cnt == 3'h7);
                end else if (fall && q.done) begin
                    d.done  = 1'b0;
                    d.state = rxem_pkg::SMB_ACK;
                    d.oe    = 1'b1;
                    unique case (q.kind)
                        rxem_pkg::KIND_ADDR: begin
                            d.rw = q.sh[0];
                            if (q.sh[7:1] != rxem_pkg::SMB_DEV_ADDR) begin
                                d.state = rxem_pkg::SMB_IDLE;
                                d.oe    = 1'b0;
                            end
                        end
                        rxem_pkg::KIND_PTR: d.ptr = q.sh;
                        default: begin
                            d.wr_stb  = 1'b1;
                            d.wr_addr = q.ptr;
                            d.wr_data = q.sh;
                            d.ptr     = q.ptr + 8'h01;
                        end
                    endcase
                end
            end
            rxem_pkg::SMB_ACK: begin
                if (fall) begin
                    d.cnt = 3'h0;
                    if (q.rw) begin
                        d.state = rxem_pkg::SMB_TX;
                        d.sh    = rd_data_in;
                        d.oe    = ~rd_data_in[7];
                    end else begin
                        d.state = rxem_pkg::SMB_RX;
                        d.oe    = 1'b0;
                        d.kind  = (q.kind == rxem_pkg::KIND_ADDR)
                                ? rxem_pkg::KIND_PTR : rxem_pkg::KIND_DATA;
                    end
                end
            end
            rxem_pkg::SMB_TX: begin
                if (rise) begin
                    d.cnt  = q.cnt + 3'h1;
                    d.done = (q.cnt == 3'h7);
                end else if (fall) begin
                    if (q.done) begin
                        d.done  = 1'b0;
                        d.oe    = 1'b0;
                        d.state = rxem_pkg::SMB_TXACK;
                        d.ptr   = q.ptr + 8'h01;
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe = ~q.sh[6];
                    end
                end
            end
            rxem_pkg::SMB_TXACK: begin
                if (rise) begin
                    d.acked = ~q.sda_s2;
                end else if (fall) begin
                    d.cnt   = 3'h0;
                    d.state = q.acked ? rxem_pkg::SMB_TX : rxem_pkg::SMB_IDLE;
                    d.sh    = rd_data_in;
                    d.oe    = q.acked & ~rd_data_in[7];
                end
            end
        endcase
        if (start) begin
            d.state = rxem_pkg::SMB_RX;
            d.kind  = rxem_pkg::KIND_ADDR;
            d.cnt   = 3'h0;
            d.done  = 1'b0;
            d.oe    = 1'b0;
        end else if (stop) begin
            d.state = rxem_pkg::SMB_IDLE;
            d.oe    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            q       <= '0;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_s3 <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_s3 <= 1'b1;
            q.state <= rxem_pkg::SMB_IDLE;
            q.kind  <= rxem_pkg::KIND_ADDR;
        end else begin
            q <= d;
        end
    end

    assign smb_sda_out    = 1'b0;
    assign smb_sda_oe_out = q.oe;
    assign wr_stb_out     = q.wr_stb;
    assign wr_addr_out    = q.wr_addr;
    assign wr_data_out    = q.wr_data;
    assign rd_addr_out    = q.ptr;

endmodule : rxem_smb_slave

//--- verilog/rxem_monitor.sv
// Receive error monitor, event counters and status registers
`timescale 1ns/1ps
module rxem_monitor (
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic       smb_scl_in,
    input  wire logic       smb_sda_in,
    output logic            smb_sda_out,
    output logic            smb_sda_oe_out,
    input  wire logic       recovered_output_clock_in,
    input  wire logic       recovery_locked_flag_in,
    input  wire logic [2:0] rate_code_in,
    input  wire logic [1:0] sig_detect_in,
    input  wire logic       data_err_in,
    input  wire logic       code_err_in,
    input  wire logic       window_tick_in,
    input  wire logic [4:0] rx_data_in,
    input  wire logic       rx_valid_in,
    output logic [4:0]      parallel_data_outputs_out,
    output logic            parallel_valid_out,
    output logic            lock_ind_out,
    output logic            rx_halted_out
);

    typedef struct packed {
        logic       rck_s1;
        logic       rck_s2;
        logic       rck_s3;
        logic       lock_s1;
        logic       lock_s2;
        logic       lock_s3;
        logic [1:0] sd_s1;
        logic [1:0] sd_s2;
        logic [2:0] rate_s1;
        logic [2:0] rate_s2;

        logic [7:0] idle_cnt;
        logic       clk_lost;

        logic [7:0] evt_cfg;
        logic [7:0] mon_ctl;
        logic [7:0] thr_lo;
        logic [7:0] thr_hi;
        logic [2:0] rate;

        logic [7:0] cdr_evt;
        logic [7:0] link_evt;
        logic [15:0] run_cnt;
        logic [15:0] win_acc;
        logic [15:0] win_prev;

        logic       halt;
        logic [4:0] par;
        logic       valid;
        logic       lock_ind;
    } rxem_mon_t;

    rxem_mon_t   q;
    rxem_mon_t   d;

    // Serial port register bus
    logic        wr_stb;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;

    // Combinational helpers
    logic        rck_edge;
    logic        clk_loss_evt;
    logic        lock_fall;
    logic        lock_rise;
    logic        counted;
    logic        new_run;
    logic [15:0] run_base;
    logic [15:0] disp_cnt;

    function automatic logic [7:0] inc8(input logic [7:0] v);
        inc8 = (v == 8'hff) ? v : v + 8'h01;
    endfunction : inc8

    function automatic logic [15:0] inc16(input logic [15:0] v);
        inc16 = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : inc16

    ////////////////////////////////////////////////////////////////////////
    // Management serial port
    rxem_smb_slave u_smb (
        .clk_sys_in     (clk_sys_in),
        .rstn_in        (rstn_in),
        .smb_scl_in     (smb_scl_in),
        .smb_sda_in     (smb_sda_in),
        .smb_sda_out    (smb_sda_out),
        .smb_sda_oe_out (smb_sda_oe_out),
        .wr_stb_out     (wr_stb),
        .wr_addr_out    (wr_addr),
        .wr_data_out    (wr_data),
        .rd_addr_out    (rd_addr),
        .rd_data_in     (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register read decode; unmapped and reserved bits read zero
    always_comb begin
        disp_cnt = q.mon_ctl[rxem_pkg::MON_WIN_SEL_BIT]
                 ? q.win_prev : q.run_cnt;                          // [R9]
        rd_data = 8'h00;
        unique case (rd_addr)
            rxem_pkg::ADDR_EVT_CFG: rd_data = q.evt_cfg;
            rxem_pkg::ADDR_MON_CTL: rd_data = q.mon_ctl;
            rxem_pkg::ADDR_THR_LO:  rd_data = q.thr_lo;
            rxem_pkg::ADDR_THR_HI:  rd_data = q.thr_hi;             // [R12]
            rxem_pkg::ADDR_RATE:
                rd_data[rxem_pkg::RATE_LSB +: 3] = q.rate;          // [R13]
            rxem_pkg::ADDR_LOCK_STAT: begin
                rd_data[rxem_pkg::STAT_LOCK_BIT] = q.lock_s2;       // [R16]
                rd_data[rxem_pkg::STAT_SD1_BIT]  = q.sd_s2[1];      // [R16]
                rd_data[rxem_pkg::STAT_SD0_BIT]  = q.sd_s2[0];      // [R16]
            end
            rxem_pkg::ADDR_EVT_STAT:
                rd_data = q.evt_cfg[rxem_pkg::EVT_SEL_BIT]
                        ? q.link_evt : q.cdr_evt;                   // [R1] [R14]
            rxem_pkg::ADDR_ERR_LO:  rd_data = disp_cnt[7:0];        // [R15]
            rxem_pkg::ADDR_ERR_HI:  rd_data = disp_cnt[15:8];       // [R15]
            default:                rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d         = q;
        d.rck_s1  = recovered_output_clock_in;
        d.rck_s2  = q.rck_s1;
        d.rck_s3  = q.rck_s2;
        d.lock_s1 = recovery_locked_flag_in;
        d.lock_s2 = q.lock_s1;
        d.lock_s3 = q.lock_s2;
        d.sd_s1   = sig_detect_in;
        d.sd_s2   = q.sd_s1;
        d.rate_s1 = rate_code_in;
        d.rate_s2 = q.rate_s1;
        d.rate    = q.lock_s2 ? q.rate_s2 : rxem_pkg::RATE_UNLOCKED; // [R13]

        // Recovered clock watchdog: one event per loss
        rck_edge     = q.rck_s2 ^ q.rck_s3;
        clk_loss_evt = 1'b0;
        if (rck_edge) begin
            d.idle_cnt = 8'h00;
            d.clk_lost = 1'b0;
        end else if (!q.clk_lost) begin
            if (q.idle_cnt == rxem_pkg::CLK_LOSS_CYC - 8'h01) begin
                d.clk_lost   = 1'b1;
                clk_loss_evt = 1'b1;
            end else begin
                d.idle_cnt = q.idle_cnt + 8'h01;
            end
        end

        // Lock edges
        lock_fall = q.lock_s3 & ~q.lock_s2;
        lock_rise = ~q.lock_s3 & q.lock_s2;

        // Recovery events
        if (q.evt_cfg[rxem_pkg::EVT_EN_BIT]
            && (lock_fall || clk_loss_evt)) begin                   // [R5]
            d.cdr_evt = inc8(q.cdr_evt);                            // [R2]
        end

        // Error counts; a new lock starts a new run unless accumulating
        counted = data_err_in
                | (code_err_in & ~q.mon_ctl[rxem_pkg::MON_CODE_DIS_BIT]); // [R7]
        new_run  = lock_rise & ~q.mon_ctl[rxem_pkg::MON_ACCUM_BIT]; // [R6]
        run_base = new_run ? 16'h0000 : q.run_cnt;
        d.run_cnt = counted ? inc16(run_base) : run_base;

        // Timing window counts
        if (window_tick_in) begin
            d.win_prev = q.win_acc;
            d.win_acc  = counted ? 16'h0001 : 16'h0000;
        end else if (counted) begin
            d.win_acc = inc16(q.win_acc);
        end

        // Halt once the run count passes the threshold
        if (new_run) begin
            d.halt = 1'b0;
        end

        if (q.run_cnt > {q.thr_hi, q.thr_lo} && !q.halt
            && !q.mon_ctl[rxem_pkg::MON_NORM_DIS_BIT]) begin        // [R11]
            d.halt = 1'b1;
            if (q.evt_cfg[rxem_pkg::EVT_EN_BIT]) begin              // [R5]
                d.link_evt = inc8(q.link_evt);
            end
        end

        if (q.mon_ctl[rxem_pkg::MON_NORM_DIS_BIT]) begin
            d.halt = 1'b0;                                          // [R10]
        end

        // Clears are levels and win over counting
        if (q.mon_ctl[rxem_pkg::MON_CLEAR_BIT]) begin
            d.run_cnt  = 16'h0000;                                  // [R8]
            d.win_acc  = 16'h0000;                                  // [R8]
            d.win_prev = 16'h0000;                                  // [R8]
            d.halt     = 1'b0;
        end

        if (q.evt_cfg[rxem_pkg::EVT_CDR_RST_BIT]) begin
            d.cdr_evt = 8'h00;                                      // [R3]
        end
        if (q.evt_cfg[rxem_pkg::EVT_LINK_RST_BIT]) begin
            d.link_evt = 8'h00;                                     // [R4]
        end

        // Output stage: data stops while halted
        d.par      = q.halt ? 5'h00 : rx_data_in;                   // [R11]
        d.valid    = ~q.halt & rx_valid_in & q.lock_s2;             // [R11]
        d.lock_ind = q.lock_s2 & ~q.halt
                   & ~(code_err_in
                       & ~q.mon_ctl[rxem_pkg::MON_CODE_DIS_BIT]);   // [R7]

        // Register writes; counter and status offsets ignore writes
        if (wr_stb) begin
            unique case (wr_addr)
                rxem_pkg::ADDR_EVT_CFG:
                    d.evt_cfg = wr_data & rxem_pkg::EVT_CFG_MASK;
                rxem_pkg::ADDR_MON_CTL:
                    d.mon_ctl = wr_data & rxem_pkg::MON_CTL_MASK;
                rxem_pkg::ADDR_THR_LO: d.thr_lo = wr_data;
                rxem_pkg::ADDR_THR_HI: d.thr_hi = wr_data;          // [R12]
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            q         <= '0;
            q.evt_cfg <= rxem_pkg::EVT_CFG_RST;
            q.mon_ctl <= rxem_pkg::MON_CTL_RST;
            q.thr_lo  <= rxem_pkg::THR_LO_RST;                      // [R11]
            q.thr_hi  <= rxem_pkg::THR_HI_RST;                      // [R12]
            q.rate    <= rxem_pkg::RATE_UNLOCKED;                   // [R13]
        end else begin
            q <= d;
        end
    end

    // Registered outputs
    assign parallel_data_outputs_out = q.par;
    assign parallel_valid_out        = q.valid;
    assign lock_ind_out              = q.lock_ind;
    assign rx_halted_out             = q.halt;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    cdr_count_a: assert property (                                  // [R2]
        q.evt_cfg[0] && !q.evt_cfg[2] && lock_fall && q.cdr_evt != 8'hff
        |=> q.cdr_evt == $past(q.cdr_evt) + 8'h01)
        else $error("recovery event count did not advance");

    cdr_reset_a: assert property (q.evt_cfg[2] |=> q.cdr_evt == 8'h00) // [R3]
        else $error("recovery event count not reset");

    link_reset_a: assert property (q.evt_cfg[1] |=> q.link_evt == 8'h00) // [R4]
        else $error("data event count not reset");

    count_hold_a: assert property (                                 // [R5]
        !q.evt_cfg[0] |=> $stable(q.cdr_evt) || q.cdr_evt == 8'h00)
        else $error("event counter advanced while disabled");

    run_keep_a: assert property (                                   // [R6]
        lock_rise && q.mon_ctl[4] && !q.mon_ctl[2]
        |=> q.run_cnt >= $past(q.run_cnt))
        else $error("accumulated error count was restarted");

    code_ignore_a: assert property (                                // [R7]
        q.mon_ctl[3] && code_err_in && !data_err_in && !lock_rise
        && !q.mon_ctl[2] |=> $stable(q.run_cnt))
        else $error("disabled code error was counted");

    err_clear_a: assert property (                                  // [R8]
        q.mon_ctl[2] |=> q.run_cnt == 16'h0000 && q.win_prev == 16'h0000)
        else $error("error counts not cleared");

    norm_stay_a: assert property (q.mon_ctl[0] |=> !q.halt)         // [R10]
        else $error("halted while threshold exit is disabled");

    halt_entry_a: assert property (                                 // [R11]
        q.run_cnt > {q.thr_hi, q.thr_lo} && !q.mon_ctl[0] && !q.mon_ctl[2]
        && !new_run |=> q.halt ##1 q.par == 5'h00 && !q.valid)
        else $error("threshold overrun did not stop data");

    rate_unlock_a: assert property (                                // [R13]
        !q.lock_s2 |=> q.rate == rxem_pkg::RATE_UNLOCKED)
        else $error("rate code shown while unlocked");

    link_hold_a: assert property (                                  // [R5]
        !q.evt_cfg[0] |=> $stable(q.link_evt) || q.link_evt == 8'h00)
        else $error("data event count advanced while disabled");

endmodule : rxem_monitor

//--- tb/rxem_host_model.sv
// Host side model: recovered clock source that can be stopped
`timescale 1ns/1ps
module rxem_host_model (
    input  wire logic run_in,
    output logic      recovered_output_clock_out
);
    // 200 ns period, off the system clock grid; holds its level when stopped
    initial begin
        recovered_output_clock_out = 1'b0;
        #7;
        forever begin
            #100;
            if (run_in) begin
                recovered_output_clock_out = ~recovered_output_clock_out;
            end
        end
    end
endmodule : rxem_host_model

//--- tb/tb.sv
// Self-checking bench for the receive error monitor
`timescale 1ns/1ps
module tb;
    logic        clk_sys_in, rstn_in, scl, m_sda, rclk, lock, derr, cerr;
    logic        wtick, rx_valid, run, sda_o, sda_oe, pvalid, lk_ind, halt;
    logic        lk;
    logic [2:0]  rate;
    logic [1:0]  sd;
    logic [4:0]  rx_data, pdata;
    logic [7:0]  v, t;
    logic [8:0]  r;
    logic [31:0] seed = 32'h49a927f0;
    int          n_fail = 0;
    int          n_tests = 0;
    logic [7:0]  ra [10] = '{8'h2b, 8'h2d, 8'h2e, 8'h2f, 8'h3b, 8'h3c,
                             8'h3d, 8'h3e, 8'h3f, 8'h30};
    logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h70, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0]  rc [3] = '{3'h1, 3'h3, 3'h6};
    // Open-drain wire with pull-up
    wire         sda = m_sda & ~(sda_oe & ~sda_o);

    rxem_monitor i_rxem_monitor (.clk_sys_in, .rstn_in, .smb_scl_in(scl),
        .smb_sda_in(sda), .smb_sda_out(sda_o), .smb_sda_oe_out(sda_oe),
        .recovered_output_clock_in(rclk), .recovery_locked_flag_in(lock),
        .rate_code_in(rate), .sig_detect_in(sd), .data_err_in(derr),
        .code_err_in(cerr), .window_tick_in(wtick), .rx_data_in(rx_data),
        .rx_valid_in(rx_valid), .parallel_data_outputs_out(pdata),
        .parallel_valid_out(pvalid), .lock_ind_out(lk_ind),
        .rx_halted_out(halt));
    rxem_host_model i_rxem_host_model (.run_in(run),
        .recovered_output_clock_out(rclk));

    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : tk

    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    // Management bus master, every phase 8 system clocks except the 2-clock hold after each clock fall in xfer
    task automatic strt;
        m_sda = 1'b1;
        tk(8);
        scl = 1'b1;
        tk(8);
        m_sda = 1'b0;
        tk(8);
        scl = 1'b0;
        tk(8);
    endtask : strt

    task automatic stp;
        m_sda = 1'b0;
        tk(8);
        scl = 1'b1;
        tk(8);
        m_sda = 1'b1;
        tk(8);
    endtask : stp

    // Eight bits and the acknowledge slot, wire sampled while clock high
    task automatic xfer(input logic [8:0] d);
        for (int i = 8; i >= 0; i--) begin
            m_sda = d[i];
            tk(8);
            scl = 1'b1;
            tk(8);
            r[i] = sda;
            scl = 1'b0;
            tk(2);
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, d);
        strt;
        xfer({rxem_pkg::SMB_DEV_ADDR, 2'b01});
        xfer({a, 1'b1});
        xfer({d, 1'b1});
        chk("ack", 8'h00, {7'h0, r[0]});
        stp;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        strt;
        xfer({rxem_pkg::SMB_DEV_ADDR, 2'b01});
        xfer({a, 1'b1});
        strt;
        xfer({rxem_pkg::SMB_DEV_ADDR, 2'b11});
        xfer(9'h1ff);
        stp;
        chk("register", e, r[8:1]);
    endtask : rd

    task automatic pz(input logic c, input int n);
        repeat (n) begin
            {cerr, derr} = {c, ~c};
            tk(1);
            lk &= lk_ind;
            {cerr, derr} = 2'b00;
            tk(1);
            lk &= lk_ind;
        end
    endtask : pz

    initial begin
        repeat (90000) @(posedge clk_sys_in);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        {scl, m_sda, lock, derr, cerr, wtick, rx_valid, run} = 8'hc0;
        {rate, sd, rx_data, rstn_in} = {3'h7, 2'h0, 5'h00, 1'b0};
        tk(20);
        rstn_in = 1'b1;
        run = 1'b1;
        tk(8);
        foreach (ra[i]) rd(ra[i], rv[i]);
        lock = 1'b1;
        foreach (rc[i]) begin
            seed = lfsr(seed);
            {rate, sd} = {rc[i], seed[1:0]};
            tk(4);
            rd(8'h3b, {1'b0, rc[i], 4'h0});
            rd(8'h3c, {4'h0, 1'b1, sd, 1'b0});
        end
        $display("test status done");
        seed = lfsr(seed);
        wr(8'h2f, seed[15:8]);
        rd(8'h2f, seed[15:8]);
        wr(8'h2f, 8'h00);
        t = 8'h2 + seed[1:0];
        wr(8'h2e, t);
        {rx_valid, rx_data} = {1'b1, seed[20:16]};
        tk(1);
        chk("data", {3'h0, seed[20:16]}, {3'h0, pdata});
        pz(1'b0, int'(t));
        tk(3);
        chk("halt", 8'h00, {7'h0, halt});
        pz(1'b0, 1);
        tk(3);
        chk("halted", 8'h20, {pvalid, halt, pdata});
        rd(8'h3e, t + 8'h1);
        rd(8'h3f, 8'h00);
        wr(8'h2d, 8'h01);
        pz(1'b0, 1);
        tk(3);
        chk("keep", 8'h02, {6'h0, pvalid, halt});
        wr(8'h2d, 8'h05);
        wr(8'h2d, 8'h00);
        rd(8'h3e, 8'h00);
        $display("test threshold done");
        wr(8'h2e, 8'hff);
        wr(8'h2d, 8'h08);
        lk = 1'b1;
        pz(1'b1, 3);
        chk("lock ind", 8'h01, {7'h0, lk});
        rd(8'h3e, 8'h00);
        wr(8'h2d, 8'h00);
        lk = 1'b1;
        pz(1'b1, 1);
        chk("lock ind", 8'h00, {7'h0, lk});
        rd(8'h3e, 8'h01);
        lock = 1'b0;
        tk(4);
        lock = 1'b1;
        rd(8'h3e, 8'h00);
        wr(8'h2d, 8'h10);
        pz(1'b0, 2);
        lock = 1'b0;
        tk(4);
        lock = 1'b1;
        rd(8'h3e, 8'h02);
        wr(8'h2d, 8'h02);
        {wtick, rx_valid} = 2'b10;
        tk(1);
        wtick = 1'b0;
        pz(1'b0, 2);
        wtick = 1'b1;
        tk(1);
        wtick = 1'b0;
        pz(1'b0, 1);
        rd(8'h3e, 8'h02);
        wr(8'h2d, 8'h00);
        $display("test monitor done");
        for (int en = 0; en < 2; en++) begin
            wr(8'h2b, 8'(en));
            run = 1'b0;
            tk(60);
            run = 1'b1;
            tk(10);
            rd(8'h3d, 8'(en));
        end
        lock = 1'b0;
        tk(4);
        lock = 1'b1;
        rd(8'h3d, 8'h02);
        wr(8'h2b, 8'h05);
        wr(8'h2b, 8'h01);
        rd(8'h3d, 8'h00);
        wr(8'h2b, 8'h09);
        wr(8'h2e, 8'h01);
        pz(1'b0, 2);
        rd(8'h3d, 8'h01);
        wr(8'h2b, 8'h0b);
        wr(8'h2b, 8'h09);
        rd(8'h3d, 8'h00);
        $display("test events done");
        tally_and_finish;
    end
endmodule : tb
